// File: src/rom_ram_io_timer_pkg.sv
// Shared constants and types for the memory, port and timer block.
package rom_ram_io_timer_pkg;

  // ----------------------------------------------------------------
  // Bus and storage geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 32;
  localparam int          BYTE_W        = 8;
  localparam int          ROM_DEPTH     = 1024;
  localparam int          RAM_DEPTH     = 64;
  localparam int          MAX_CHIPS     = 7;

  // ----------------------------------------------------------------
  // Byte addresses of the register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ROM_BASE      = 16'h0000;
  localparam logic [15:0] RAM_BASE      = 16'h1000;
  localparam logic [15:0] PORTA_DATA    = 16'h1100;
  localparam logic [15:0] PORTA_DIR     = 16'h1104;
  localparam logic [15:0] PORTB_DATA    = 16'h1108;
  localparam logic [15:0] PORTB_DIR     = 16'h110C;
  localparam logic [15:0] TIMER_BASE    = 16'h1140;
  localparam logic [15:0] IRQ_STATUS    = 16'h1200;
  localparam logic [15:0] IRQ_MASK      = 16'h1204;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          TMR_SEL_LSB   = 2;
  localparam int          TMR_FLAG_SEL  = 4;
  localparam int          TMR_ALERT_BIT = 5;
  localparam int          FLAG_BIT      = 7;
  localparam int          ALERT_PIN     = 7;
  localparam int          IRQ_W         = 2;
  localparam int          IRQ_TIMER     = 0;
  localparam int          IRQ_BUSERR    = 1;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  PORT_RESET    = 8'h00;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam int          PRESC_W       = 10;
  localparam logic [15:0] PRESC_SHIFTS  = 16'hA630;
  localparam int          MAX_INTERVAL  = 262144;

  typedef enum logic [2:0] {
    REGION_NONE  = 3'b000,
    REGION_ROM   = 3'b001,
    REGION_RAM   = 3'b010,
    REGION_PORT  = 3'b011,
    REGION_TIMER = 3'b100,
    REGION_IRQ   = 3'b101
  } region_e;

endpackage : rom_ram_io_timer_pkg

// File: src/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  // ----------------------------------------------------------------
  // Per-bit flop pairs
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else begin
        meta_q <= pinIn[i];
        sync_q <= meta_q;
      end
    end
    assign pinSync[i] = sync_q;
  end

endmodule : pin_sync

// File: src/interval_timer.sv
// Eight-bit interval timer with selectable prescale and sticky flag.
`timescale 1ns/1ps
module interval_timer (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [7:0] loadCount,
  input  wire logic [1:0] loadSel,
  input  wire logic       access,
  output logic      [7:0] count,
  output logic            flag,
  output logic            expire
);

  localparam int PW = rom_ram_io_timer_pkg::PRESC_W;

  logic [PW-1:0] presc_q;
  logic [1:0]    sel_q;
  logic [7:0]    count_q;
  logic          flag_q;
  logic          divOne_q;
  logic          tick;

  function automatic logic [PW-1:0] divMinusOne(input logic [1:0] sel);
    logic [3:0]    shift;
    logic [PW:0]   full;
    shift = rom_ram_io_timer_pkg::PRESC_SHIFTS[sel*4 +: 4];
    full  = (PW+1)'(1) << shift;
    return PW'(full - (PW+1)'(1));
  endfunction : divMinusOne

  assign tick   = (presc_q == '0);
  assign expire = ce & tick & ~load & (count_q == 8'h00);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Prescale reload select
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      presc_q <= '0;
      sel_q   <= 2'h0;
    end else if (ce) begin
      if (load) begin
        presc_q <= divMinusOne(loadSel);
        sel_q   <= loadSel;
      end else if (tick) begin
        presc_q <= (divOne_q | expire) ? '0 : divMinusOne(sel_q);
      end else begin
        presc_q <= presc_q - PW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and divide-by-one mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_q  <= 8'h00;
      divOne_q <= 1'b0;
    end else if (ce) begin
      if (load) begin
        count_q  <= loadCount;
        divOne_q <= 1'b0;
      end else begin
        if (tick) begin
          count_q <= count_q - 8'h01;
        end
        if (expire) begin
          divOne_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky flag
  // ----------------------------------------------------------------
  // Access clears flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (expire) begin
        flag_q <= 1'b1;
      end else if (access) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign count = count_q;
  assign flag  = flag_q;

endmodule : interval_timer

// File: src/rom_ram_io_timer_host_port.sv
// Memory, port and interval timer array reached over APB.
//
// Notes on behaviour
// - Initialisation clears both direction and both output registers so every port pin is an input.
// - While initialisation is held the host data drivers stay off.
// - Initialisation turns off the timer alert, but the timer keeps running and can still raise irqOut after it.
// - A high direction line writes to the device and a low one reads from it.
// - Host data drivers are on only during a read access.
// - The alert pin idles high, goes low for a timer interrupt and is port B top bit otherwise.
// - The block holds a 1024 byte read-only store, a 64 byte store and two 8-bit ports.
// - The timer spans one to 262,144 clock periods.
// - Up to seven such blocks share the bus, all decoding the same read-only store addresses; CHIP_INDEX only alters the contents.
// - A direction bit of one drives the output bit and a zero leaves the pin an input held high.
// - Port reads return pins for inputs and output bits for outputs and never change the outputs.
// - A timer write picks prescale 1, 8, 64 or 1024 by two address bits and a third enables the alert.
// - Any timer access clears the flag unless it coincides with the flag being set.
`timescale 1ns/1ps
module rom_ram_io_timer_host_port #(
  parameter int         CHIP_INDEX = 0,
  parameter logic [7:0] ROM_SEED   = 8'h5A
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irqOut,
  input  wire logic        initLowIn,
  output logic      [7:0]  hostDataLines,
  output logic             hostDataOe,
  input  wire logic [7:0]  portAIn,
  output logic      [7:0]  portAOut,
  output logic      [7:0]  portAOe,
  input  wire logic [7:0]  portBIn,
  output logic      [7:0]  portBOut,
  output logic      [7:0]  portBOe
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Shared bus chip count
  if (CHIP_INDEX < 0 || CHIP_INDEX >= rom_ram_io_timer_pkg::MAX_CHIPS) begin : g_bad_chip
    $error("CHIP_INDEX must be below the shared chip count");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int RAM_AW = $clog2(rom_ram_io_timer_pkg::RAM_DEPTH);
  localparam int ROM_AW = $clog2(rom_ram_io_timer_pkg::ROM_DEPTH);

  logic [16:0]                  syncPins;
  logic                         initActive;
  logic                         clearAll;
  logic [7:0]                   pinA;
  logic [7:0]                   pinB;
  logic                         setup;
  logic                         access;
  logic                         wrAcc;
  logic                         rdAcc;
  rom_ram_io_timer_pkg::region_e region;
  logic                         badAccess;
  logic [7:0]                   wrByte;
  logic [7:0]                   readA;
  logic [7:0]                   readB;
  logic [7:0]                   readByte;
  logic [7:0]                   ddrA_q;
  logic [7:0]                   dataA_q;
  logic [7:0]                   ddrB_q;
  logic [7:0]                   dataB_q;
  logic [7:0]                   ram_q [rom_ram_io_timer_pkg::RAM_DEPTH];
  logic                         alertEn_q;
  logic                         alertActive;
  logic [1:0]                   irqStatus_q;
  logic [1:0]                   irqMask_q;
  logic [1:0]                   irqEvents;
  logic [31:0]                  prdata_q;
  logic                         slvErr_q;
  logic                         timerLoad;
  logic                         timerAccess;
  logic [7:0]                   timerCount;
  logic                         timerFlag;
  logic                         timerExpire;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic rom_ram_io_timer_pkg::region_e regionOf(input logic [15:0] a);
    if (a[15:12] == rom_ram_io_timer_pkg::ROM_BASE[15:12]) begin
      return rom_ram_io_timer_pkg::REGION_ROM;
    end else if (a[15:8] == rom_ram_io_timer_pkg::RAM_BASE[15:8]) begin
      return rom_ram_io_timer_pkg::REGION_RAM;
    end else if (a[15:4] == rom_ram_io_timer_pkg::PORTA_DATA[15:4]) begin
      return rom_ram_io_timer_pkg::REGION_PORT;
    end else if (a[15:6] == rom_ram_io_timer_pkg::TIMER_BASE[15:6]) begin
      return rom_ram_io_timer_pkg::REGION_TIMER;
    end else if (a[15:3] == rom_ram_io_timer_pkg::IRQ_STATUS[15:3]) begin
      return rom_ram_io_timer_pkg::REGION_IRQ;
    end else begin
      return rom_ram_io_timer_pkg::REGION_NONE;
    end
  endfunction : regionOf

  function automatic logic [7:0] romByte(input logic [ROM_AW-1:0] idx);
    return idx[7:0] ^ {idx[9:8], 6'h00} ^ ROM_SEED ^ 8'(CHIP_INDEX);
  endfunction : romByte

  function automatic logic [7:0] portRead(input logic [7:0] ddr, input logic [7:0] data,
                                          input logic [7:0] pin);
    return (ddr & data) | (~ddr & pin);
  endfunction : portRead

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (17)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   ({initLowIn, portBIn, portAIn}),
    .pinSync (syncPins)
  );

  assign pinA       = syncPins[7:0];
  assign pinB       = syncPins[15:8];
  assign initActive = ~syncPins[16];
  assign clearAll   = reset | (ce & initActive);

  // ----------------------------------------------------------------
  // Bus phases and decode
  // ----------------------------------------------------------------
  assign setup  = ce & psel & ~penable;
  assign access = ce & psel & penable;
  assign wrAcc  = access & pwrite;
  assign rdAcc  = access & ~pwrite;
  assign region = regionOf(paddr);
  assign wrByte = pwdata[7:0];

  always_comb begin
    badAccess = 1'b0;
    case (region)
      rom_ram_io_timer_pkg::REGION_NONE: begin
        badAccess = 1'b1;
      end
      rom_ram_io_timer_pkg::REGION_ROM: begin
        badAccess = pwrite;
      end
      rom_ram_io_timer_pkg::REGION_IRQ: begin
        badAccess = pwrite && (paddr != rom_ram_io_timer_pkg::IRQ_MASK);
      end
      default: begin
        badAccess = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  // Init clears port registers
  always_ff @(posedge clk_sys) begin
    if (clearAll) begin
      ddrA_q  <= rom_ram_io_timer_pkg::PORT_RESET;
      dataA_q <= rom_ram_io_timer_pkg::PORT_RESET;
      ddrB_q  <= rom_ram_io_timer_pkg::PORT_RESET;
      dataB_q <= rom_ram_io_timer_pkg::PORT_RESET;
    end else if (wrAcc && region == rom_ram_io_timer_pkg::REGION_PORT) begin
      case (paddr)
        rom_ram_io_timer_pkg::PORTA_DATA: begin
          dataA_q <= wrByte;
        end
        rom_ram_io_timer_pkg::PORTA_DIR: begin
          ddrA_q <= wrByte;
        end
        rom_ram_io_timer_pkg::PORTB_DATA: begin
          dataB_q <= wrByte;
        end
        rom_ram_io_timer_pkg::PORTB_DIR: begin
          ddrB_q <= wrByte;
        end
        default: begin
          dataA_q <= dataA_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Scratch store
  // ----------------------------------------------------------------
  // Sixty-four byte store
  always_ff @(posedge clk_sys) begin
    if (wrAcc && region == rom_ram_io_timer_pkg::REGION_RAM) begin
      ram_q[paddr[RAM_AW+1:2]] <= wrByte;
    end
  end

  // ----------------------------------------------------------------
  // Interval timer and alert enable
  // ----------------------------------------------------------------
  assign timerLoad   = wrAcc & (region == rom_ram_io_timer_pkg::REGION_TIMER);
  assign timerAccess = access & (region == rom_ram_io_timer_pkg::REGION_TIMER);

  interval_timer u_timer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .ce        (ce),
    .load      (timerLoad),
    .loadCount (wrByte),
    .loadSel   (paddr[rom_ram_io_timer_pkg::TMR_SEL_LSB +: 2]),
    .access    (timerAccess),
    .count     (timerCount),
    .flag      (timerFlag),
    .expire    (timerExpire)
  );

  always_ff @(posedge clk_sys) begin
    if (clearAll) begin
      alertEn_q <= 1'b0;
    end else if (timerAccess) begin
      alertEn_q <= paddr[rom_ram_io_timer_pkg::TMR_ALERT_BIT];
    end
  end

  assign alertActive = alertEn_q & timerFlag;

  // ----------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------
  // Pin or output bit
  assign readA = portRead(ddrA_q, dataA_q, pinA);
  assign readB = portRead(ddrB_q, dataB_q, pinB);

  always_comb begin
    readByte = 8'h00;
    case (region)
      rom_ram_io_timer_pkg::REGION_ROM: begin
        readByte = romByte(paddr[ROM_AW+1:2]);
      end
      rom_ram_io_timer_pkg::REGION_RAM: begin
        readByte = ram_q[paddr[RAM_AW+1:2]];
      end
      rom_ram_io_timer_pkg::REGION_PORT: begin
        case (paddr)
          rom_ram_io_timer_pkg::PORTA_DATA: readByte = readA;
          rom_ram_io_timer_pkg::PORTA_DIR:  readByte = ddrA_q;
          rom_ram_io_timer_pkg::PORTB_DATA: readByte = readB;
          rom_ram_io_timer_pkg::PORTB_DIR:  readByte = ddrB_q;
          default:                          readByte = 8'h00;
        endcase
      end
      rom_ram_io_timer_pkg::REGION_TIMER: begin
        if (paddr[rom_ram_io_timer_pkg::TMR_FLAG_SEL]) begin
          readByte = {timerFlag, 7'h00};
        end else begin
          readByte = timerCount;
        end
      end
      rom_ram_io_timer_pkg::REGION_IRQ: begin
        if (paddr == rom_ram_io_timer_pkg::IRQ_STATUS) begin
          readByte = {6'h00, irqStatus_q};
        end else begin
          readByte = {6'h00, irqMask_q};
        end
      end
      default: begin
        readByte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
      slvErr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
      slvErr_q <= badAccess;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign irqEvents = {access & slvErr_q, timerExpire};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqStatus_q <= rom_ram_io_timer_pkg::IRQ_RESET;
    end else if (ce) begin
      if (rdAcc && paddr == rom_ram_io_timer_pkg::IRQ_STATUS) begin
        irqStatus_q <= (irqStatus_q & ~prdata_q[1:0]) | irqEvents;
      end else begin
        irqStatus_q <= irqStatus_q | irqEvents;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqMask_q <= rom_ram_io_timer_pkg::IRQ_RESET;
    end else if (wrAcc && paddr == rom_ram_io_timer_pkg::IRQ_MASK) begin
      irqMask_q <= pwdata[1:0];
    end
  end

  assign irqOut = |(irqStatus_q & irqMask_q);

  // ----------------------------------------------------------------
  // Bus and host data outputs
  // ----------------------------------------------------------------
  assign prdata        = prdata_q;
  assign pready        = ce;
  assign pslverr       = psel & penable & slvErr_q;
  assign hostDataLines = prdata_q[7:0];
  assign hostDataOe    = psel & penable & ~pwrite & ~initActive & ~reset;

  // ----------------------------------------------------------------
  // Peripheral pin drive
  // ----------------------------------------------------------------
  // Direction bit drives pin
  assign portAOut = dataA_q | ~ddrA_q;
  assign portAOe  = ddrA_q;

  assign portBOut = {~alertActive & (dataB_q[7] | ~ddrB_q[7]), dataB_q[6:0] | ~ddrB_q[6:0]};
  assign portBOe  = {ddrB_q[7] | alertActive, ddrB_q[6:0]};

endmodule : rom_ram_io_timer_host_port

// File: tb/rom_ram_io_timer_host_port_props.sv
// Assertion checker for the memory, port and timer block.
`timescale 1ns/1ps
module rom_ram_io_timer_host_port_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irqOut,
  input wire logic        initLowIn,
  input wire logic [7:0]  hostDataLines,
  input wire logic        hostDataOe,
  input wire logic [7:0]  portAIn,
  input wire logic [7:0]  portAOut,
  input wire logic [7:0]  portAOe,
  input wire logic [7:0]  portBIn,
  input wire logic [7:0]  portBOut,
  input wire logic [7:0]  portBOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  AST_OE_READ: assert property (disable iff (reset) hostDataOe |-> psel && penable && !pwrite)
    else $error("data drivers on outside a read");
  AST_OE_RESET: assert property (reset |-> !hostDataOe)
    else $error("data drivers on during reset");
  AST_WRITE_IN: assert property (disable iff (reset) psel && pwrite |-> !hostDataOe)
    else $error("data drivers on during a write");
  AST_PREADY: assert property (disable iff (reset) pready == ce)
    else $error("ready does not follow clock enable");
  AST_PULL_A: assert property (disable iff (reset) (~portAOe & ~portAOut) == 8'h00)
    else $error("port A input pin not held high");
  AST_PULL_B: assert property (disable iff (reset) (~portBOe[6:0] & ~portBOut[6:0]) == 7'h00)
    else $error("port B input pin not held high");
  AST_RESET_PORTS: assert property (reset |=> portAOe == 8'h00 && portBOe == 8'h00 && !irqOut)
    else $error("reset left a port output or alert on");
  AST_DIR_WRITE: assert property (disable iff (reset)
    psel && penable && pwrite && ce && paddr == rom_ram_io_timer_pkg::PORTA_DIR && initLowIn
    && $past(initLowIn) && $past(initLowIn, 2) |=> portAOe == $past(pwdata[7:0]))
    else $error("direction write not applied");
  AST_ROM_REFUSE: assert property (disable iff (reset)
    psel && !penable && ce && pwrite && paddr < rom_ram_io_timer_pkg::RAM_BASE ##1 psel && penable |-> pslverr)
    else $error("write to read-only store not refused");
endmodule : rom_ram_io_timer_host_port_props

bind rom_ram_io_timer_host_port rom_ram_io_timer_host_port_props chk (
  .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqOut(irqOut),
  .initLowIn(initLowIn), .hostDataLines(hostDataLines), .hostDataOe(hostDataOe), .portAIn(portAIn),
  .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe));

// File: tb/pin_model.sv
// Peripheral pin model: resolves one 8-bit port against an outside driver.
`timescale 1ns/1ps
module pin_model (
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  output logic      [7:0] pin
);
  assign pin = (oe & out) | (~oe & extEn & extVal) | (~oe & ~extEn);
endmodule : pin_model

// File: tb/rom_ram_io_timer_host_port_tb.sv
// Self-checking testbench for the memory, port and timer block.
`timescale 1ns/1ps
module rom_ram_io_timer_host_port_tb;
  localparam int         CHIP = 3;
  localparam logic [7:0] SEED = 8'h3C;
  logic        clk_sys, reset, ce, psel, penable, pwrite, initLowIn, pslverr, pready, irqOut, hostDataOe, lastErr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rnd, expV;
  logic [7:0]  hostDataLines, portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, eEn, eVal, d, v;
  logic [7:0]  mem [4];
  logic [31:0] expQ [$];
  int          n_errors, comparisons, cnt, dv;

  rom_ram_io_timer_host_port #(.CHIP_INDEX(CHIP), .ROM_SEED(SEED)) DUT (.clk_sys(clk_sys), .reset(reset),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irqOut(irqOut), .initLowIn(initLowIn), .hostDataLines(hostDataLines),
    .hostDataOe(hostDataOe), .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn),
    .portBOut(portBOut), .portBOe(portBOe));
  pin_model pa (.out(portAOut), .oe(portAOe), .extEn(eEn), .extVal(eVal), .pin(portAIn));
  pin_model pb (.out(portBOut), .oe(portBOe), .extEn(eEn), .extVal(eVal), .pin(portBIn));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dat);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 100);
    if (pready !== 1'b1) n_errors++;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      expV = expQ.pop_front();
      check(prdata, expV);
      check(hostDataLines, expV[7:0]);
      check(hostDataOe, 1'b1);
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end

  initial begin
    {reset, ce, initLowIn} = 3'b111;
    {psel, penable, pwrite, paddr, pwdata, eEn, eVal} = '0;
    rnd = 32'hf416531d;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check({portAOe, portBOe, 7'h00, irqOut, 7'h00, hostDataOe}, 32'h0);
    check(portAOut, 8'hFF);
    @(posedge clk_sys);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      mem[i] = rnd[7:0];
      apb(1'b1, rom_ram_io_timer_pkg::RAM_BASE + 16'(4 * (i == 3 ? 63 : i)), rnd);
    end
    for (int i = 0; i < 4; i++) rd(rom_ram_io_timer_pkg::RAM_BASE + 16'(4 * (i == 3 ? 63 : i)), {24'h0, mem[i]});
    $display("ram test done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      cnt = (i == 0) ? 0 : (i == 1) ? 1023 : int'(rnd[9:0]);
      rd(16'(4 * cnt), {24'h0, 8'(cnt) ^ {cnt[9:8], 6'h00} ^ SEED ^ 8'(CHIP)});
    end
    apb(1'b1, 16'h0004, rnd);
    check(lastErr, 1'b1);
    rd(16'h0004, {24'h0, 8'h01 ^ SEED ^ 8'(CHIP)});
    rd(16'h2000, 32'h0);
    check(lastErr, 1'b1);
    rd(rom_ram_io_timer_pkg::IRQ_STATUS, 32'h3);
    $display("rom test done");
    for (int p = 0; p < 2; p++) begin
      rnd = lfsr(rnd);
      d = rnd[7:0] & (p == 1 ? 8'h7F : 8'hFF);
      v = rnd[15:8];
      eEn <= rnd[31:24];
      eVal <= rnd[23:16];
      apb(1'b1, rom_ram_io_timer_pkg::PORTA_DIR + 16'(8 * p), {24'h0, d});
      apb(1'b1, rom_ram_io_timer_pkg::PORTA_DATA + 16'(8 * p), {24'h0, v});
      repeat (4) @(posedge clk_sys);
      check(p == 1 ? {portBOe, portBOut} : {portAOe, portAOut}, {d, v | ~d});
      for (int k = 0; k < 2; k++) rd(rom_ram_io_timer_pkg::PORTA_DATA + 16'(8 * p),
        {24'h0, (d & v) | (~d & ((rnd[31:24] & rnd[23:16]) | ~rnd[31:24]))});
    end
    $display("port test done");
    apb(1'b1, rom_ram_io_timer_pkg::PORTB_DIR, 32'hFF);
    apb(1'b1, rom_ram_io_timer_pkg::TIMER_BASE + 16'h0020, 32'hFF);
    initLowIn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check({portAOe, portBOe, portAOut, portBOut}, 32'h0000_FFFF);
    check(hostDataOe, 1'b0);
    @(posedge clk_sys);
    initLowIn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    $display("init test done");
    apb(1'b1, rom_ram_io_timer_pkg::IRQ_MASK, 32'h1);
    for (int s = 0; s < 4; s++) begin
      dv = (s == 3) ? 1024 : (1 << (3 * s));
      apb(1'b1, rom_ram_io_timer_pkg::TIMER_BASE + 16'h0020 + 16'(4 * s), 32'h0);
      cnt = 0;
      while (irqOut !== 1'b1 && cnt < 2000) begin
        @(posedge clk_sys);
        cnt++;
      end
      check(cnt + 2 >= dv && cnt <= dv + 4, 1'b1);
      @(negedge clk_sys);
      check({portBOe[7], portBOut[7]}, 2'b10);
      @(posedge clk_sys);
      rd(rom_ram_io_timer_pkg::TIMER_BASE + 16'h0010, 32'h80);
      rd(rom_ram_io_timer_pkg::IRQ_STATUS, 32'h1);
      @(negedge clk_sys);
      check({irqOut, portBOe[7]}, 2'b00);
      @(posedge clk_sys);
      rd(rom_ram_io_timer_pkg::TIMER_BASE + 16'h0010, 32'h0);
    end
    apb(1'b1, rom_ram_io_timer_pkg::TIMER_BASE + 16'h000C, 32'h40);
    rd(rom_ram_io_timer_pkg::TIMER_BASE + 16'h000C, 32'h40);
    $display("timer test done");
    finish_test();
  end
endmodule : rom_ram_io_timer_host_port_tb
